// file: design/converter_fault_protection.v
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fault_prot_regs.vh"
module converter_fault_protection (
    input wire clk_in,
    input wire rst_n_in,
    // classic wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [5:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    output wire wb_err_out,
    // asynchronous comparator results
    input wire supply_below_in,
    input wire switch_drop_over_in,
    input wire out_below_in,
    input wire out_above_in,
    input wire overtemp_in,
    // pwm drive from the modulator, same clock
    input wire pwm_high_in,
    input wire pwm_low_in,
    output reg high_side_gate_drive_out,
    output reg low_side_gate_drive_out,
    output wire irq_out
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [`CTRL_W-1:0] ctrl;
    reg [`BLANK_CODE_W-1:0] blanking_length_field;
    reg [`FLG_W-1:0] status;
    reg [`FLG_W-1:0] mask;
    reg [`BLANK_CNT_W-1:0] blank_cnt;
    reg pwm_high_d;

    wire [`FLG_W-1:0] cmp_sync;
    wire supply_below_s;
    wire switch_drop_s;
    wire out_below_s;
    wire out_above_s;
    wire overtemp_s;

    wire input_low_flag;
    wire output_low_flag;
    wire output_high_flag;
    wire overtemp_enable;
    wire overcurrent_enable;

    wire bus_req;
    wire [3:0] reg_idx;
    wire addr_ok;
    wire wr_en;
    wire [`FLG_W-1:0] clr_bits;
    wire [`FLG_W-1:0] set_bits;
    wire oc_window;
    wire blank_done;
    wire force_low;
    reg [31:0] next_rdata;

    // ----------------------------------------
    // comparator synchronisers
    // ----------------------------------------
    sync_two_flop #(
        .WIDTH(`FLG_W)
    ) u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in({overtemp_in, out_above_in, out_below_in, switch_drop_over_in,
            supply_below_in}),
        .sync_out(cmp_sync)
    );

    assign supply_below_s = cmp_sync[`FLG_INPUT_LOW];
    assign switch_drop_s = cmp_sync[`FLG_OC];
    assign out_below_s = cmp_sync[`FLG_OUT_LOW];
    assign out_above_s = cmp_sync[`FLG_OUT_HIGH];
    assign overtemp_s = cmp_sync[`FLG_OVERTEMP];

    assign overtemp_enable = ctrl[`CTRL_OVERTEMP_EN];
    assign overcurrent_enable = ctrl[`CTRL_OC_EN];

    // ----------------------------------------
    // blanking length lookup
    // ----------------------------------------
    function [`BLANK_CNT_W-1:0] blank_cycles;
        input [`BLANK_CODE_W-1:0] code;
        begin
            case (code)
                2'h0: blank_cycles = `BLANK_CYC_0;
                2'h1: blank_cycles = `BLANK_CYC_1;
                2'h2: blank_cycles = `BLANK_CYC_2;
                default: blank_cycles = `BLANK_CYC_3;
            endcase
        end
    endfunction

    // ----------------------------------------
    // leading-edge blanking of the overcurrent compare
    // ----------------------------------------
    // counter restarts on each rising edge of the registered high-side gate drive
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_high_d <= 1'b0;
            blank_cnt <= {`BLANK_CNT_W{1'b0}};
        end else begin
            pwm_high_d <= high_side_gate_drive_out;
            if (high_side_gate_drive_out && !pwm_high_d) begin
                blank_cnt <= blank_cycles(blanking_length_field);
            end else if (!high_side_gate_drive_out) begin
                blank_cnt <= {`BLANK_CNT_W{1'b0}};
            end else if (blank_cnt != {`BLANK_CNT_W{1'b0}}) begin
                blank_cnt <= blank_cnt - 8'h01;
            end
        end
    end

    assign blank_done = high_side_gate_drive_out && pwm_high_d &&
        (blank_cnt == {`BLANK_CNT_W{1'b0}});
    // only while the high side really conducts
    assign oc_window = overcurrent_enable && blank_done;

    // ----------------------------------------
    // fault flag set terms
    // ----------------------------------------
    // set terms ignore mask and global enable entirely
    assign set_bits[`FLG_INPUT_LOW] = ctrl[`CTRL_LOCKOUT_EN] && supply_below_s;
    assign set_bits[`FLG_OC] = oc_window && switch_drop_s;
    assign set_bits[`FLG_OUT_LOW] = ctrl[`CTRL_OUT_LOW_MON] && out_below_s;
    assign set_bits[`FLG_OUT_HIGH] = ctrl[`CTRL_OUT_HIGH_MON] && out_above_s;
    assign set_bits[`FLG_OVERTEMP] = overtemp_enable && overtemp_s;

    // ----------------------------------------
    // wishbone decode
    // ----------------------------------------
    assign bus_req = wb_cyc_in && wb_stb_in;
    assign reg_idx = wb_adr_in[5:2];
    assign addr_ok = (reg_idx <= `ADDR_FLAGS);
    assign wr_en = bus_req && wb_we_in && !wb_ack_out && addr_ok;
    // unmapped addresses still ack; reads return zero, writes are dropped
    assign wb_err_out = 1'b0;
    assign clr_bits = (wr_en && reg_idx == `ADDR_STATUS && wb_sel_in[0]) ?
        wb_dat_in[`FLG_W-1:0] : {`FLG_W{1'b0}};

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= bus_req && !wb_ack_out;
        end
    end

    // ----------------------------------------
    // control and mask registers
    // ----------------------------------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `CTRL_RESET;
            blanking_length_field <= `BLANK_RESET;
            mask <= `FLG_RESET;
        end else if (wr_en) begin
            case (reg_idx)
                `ADDR_CTRL: begin
                    if (wb_sel_in[0]) begin
                        ctrl[7:0] <= wb_dat_in[7:0];
                    end
                    if (wb_sel_in[1]) begin
                        ctrl[`CTRL_W-1:8] <= wb_dat_in[`CTRL_W-1:8];
                    end
                end
                `ADDR_BLANK: begin
                    if (wb_sel_in[0]) begin
                        blanking_length_field <= wb_dat_in[`BLANK_CODE_W-1:0];
                    end
                end
                `ADDR_MASK: begin
                    if (wb_sel_in[0]) begin
                        mask <= wb_dat_in[`FLG_W-1:0];
                    end
                end
                default: begin
                    mask <= mask;
                end
            endcase
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // input-low follows the comparator; the others are sticky, set wins over clear
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status <= `FLG_RESET;
        end else begin
            status[`FLG_INPUT_LOW] <= set_bits[`FLG_INPUT_LOW];
            status[`FLG_OC] <= set_bits[`FLG_OC] |
                (status[`FLG_OC] & ~clr_bits[`FLG_OC]);
            status[`FLG_OUT_LOW] <= set_bits[`FLG_OUT_LOW] |
                (status[`FLG_OUT_LOW] & ~clr_bits[`FLG_OUT_LOW]);
            status[`FLG_OUT_HIGH] <= set_bits[`FLG_OUT_HIGH] |
                (status[`FLG_OUT_HIGH] & ~clr_bits[`FLG_OUT_HIGH]);
            status[`FLG_OVERTEMP] <= set_bits[`FLG_OVERTEMP] |
                (status[`FLG_OVERTEMP] & ~clr_bits[`FLG_OVERTEMP]);
        end
    end

    assign input_low_flag = status[`FLG_INPUT_LOW];
    assign output_low_flag = status[`FLG_OUT_LOW];
    assign output_high_flag = status[`FLG_OUT_HIGH];

    assign irq_out = ctrl[`CTRL_GIE] && |(status & mask);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always @* begin
        next_rdata = 32'h00000000;
        case (reg_idx)
            `ADDR_CTRL: next_rdata[`CTRL_W-1:0] = ctrl;
            `ADDR_BLANK: next_rdata[`BLANK_CODE_W-1:0] = blanking_length_field;
            `ADDR_STATUS: next_rdata[`FLG_W-1:0] = status;
            `ADDR_MASK: next_rdata[`FLG_W-1:0] = mask;
            `ADDR_FLAGS: next_rdata[`FLG_W-1:0] = cmp_sync;
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_dat_out <= 32'h00000000;
        end else if (bus_req && !wb_ack_out) begin
            wb_dat_out <= next_rdata;
        end
    end

    // ----------------------------------------
    // gate drive with fault override
    // ----------------------------------------
    // overtemp acts on the live synchronised level so it needs no firmware
    assign force_low = (ctrl[`CTRL_OUT_LOW_SD] && output_low_flag) ||
        (ctrl[`CTRL_OUT_HIGH_SD] && output_high_flag) ||
        (overtemp_enable && overtemp_s) ||
        ctrl[`CTRL_DRV_DIS];

    // registered to keep the gate pins glitch free; costs one cycle of latency
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            high_side_gate_drive_out <= 1'b0;
            low_side_gate_drive_out <= 1'b0;
        end else begin
            high_side_gate_drive_out <= pwm_high_in && !force_low &&
                !ctrl[`CTRL_HI_DIS];
            low_side_gate_drive_out <= pwm_low_in && !force_low &&
                !ctrl[`CTRL_LO_DIS];
        end
    end
endmodule // converter_fault_protection

// file: design/fault_prot_regs.vh
`ifndef FAULT_PROT_REGS_VH
`define FAULT_PROT_REGS_VH

// ----------------------------------------
// register word indices, compared with wb_adr_in[5:2]
// ----------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_BLANK 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_MASK 4'h3
`define ADDR_FLAGS 4'h4

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_LOCKOUT_EN 0
`define CTRL_OC_EN 1
`define CTRL_OUT_LOW_MON 2
`define CTRL_OUT_HIGH_MON 3
`define CTRL_OUT_LOW_SD 4
`define CTRL_OUT_HIGH_SD 5
`define CTRL_OVERTEMP_EN 6
`define CTRL_GIE 7
`define CTRL_DRV_DIS 8
`define CTRL_HI_DIS 9
`define CTRL_LO_DIS 10
`define CTRL_W 11
`define CTRL_RESET 11'h000

// ----------------------------------------
// flag / status bits
// ----------------------------------------
`define FLG_INPUT_LOW 0
`define FLG_OC 1
`define FLG_OUT_LOW 2
`define FLG_OUT_HIGH 3
`define FLG_OVERTEMP 4
`define FLG_W 5
`define FLG_RESET 5'h00

// ----------------------------------------
// blanking lengths in core clock cycles, per two-bit code
// ----------------------------------------
`define BLANK_CODE_W 2
`define BLANK_CYC_0 8'h02
`define BLANK_CYC_1 8'h04
`define BLANK_CYC_2 8'h06
`define BLANK_CYC_3 8'h08
`define BLANK_CNT_W 8
`define BLANK_RESET 2'h0

`endif

// file: design/sync_two_flop.v
`timescale 1ns/1ps
module sync_two_flop #(
    parameter WIDTH = 5
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;

    // first stage feeds only the second stage
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_one <= {WIDTH{1'b0}};
            stage_two <= {WIDTH{1'b0}};
        end else begin
            stage_one <= async_in;
            stage_two <= stage_one;
        end
    end

    assign sync_out = stage_two;
endmodule // sync_two_flop

// file: verification/fault_comparators.sv
`timescale 1ns/1ps
module fault_comparators (
    input wire logic [4:0] level_in,
    output logic [4:0] comp_out
);
    // analog comparators switch unrelated to the core clock
    initial comp_out = 5'h00;
    always @(level_in) begin
        comp_out <= #13 level_in;
    end
endmodule // fault_comparators

// file: verification/fault_prot_properties.sv
`timescale 1ns/1ps
module fault_prot_properties (
    input wire clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [5:0] wb_adr_in,
    input wire [31:0] wb_dat_in,
    input wire wb_ack_out,
    input wire wb_err_out,
    input wire out_below_in,
    input wire out_above_in,
    input wire overtemp_in,
    input wire pwm_high_in,
    input wire pwm_low_in,
    input wire high_side_gate_drive_out,
    input wire low_side_gate_drive_out,
    input wire irq_out
);
    reg [10:0] ctl;
    wire drv_off = !high_side_gate_drive_out && !low_side_gate_drive_out;
    // ctrl mirror, loaded at the edge that takes the write
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ctl <= 11'h000;
        else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_adr_in[5:2] == 4'h0)
            ctl <= wb_dat_in[10:0];
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    ack_resp_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not answered");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    err_low_a: assert property (!wb_err_out)
        else $error("error response seen");
    high_src_a: assert property (high_side_gate_drive_out |->
        $past(pwm_high_in) && !$past(ctl[8]) && !$past(ctl[9]))
        else $error("high drive without request");
    low_src_a: assert property (low_side_gate_drive_out |->
        $past(pwm_low_in) && !$past(ctl[8]) && !$past(ctl[10]))
        else $error("low drive without request");
    ot_stop_a: assert property ((ctl[6] && overtemp_in) [*4] |-> drv_off)
        else $error("overtemp did not stop drives");
    ol_stop_a: assert property ((ctl[2] && ctl[4] && out_below_in) [*5] |-> drv_off)
        else $error("output low did not stop drives");
    oh_stop_a: assert property ((ctl[3] && ctl[5] && out_above_in) [*5] |-> drv_off)
        else $error("output high did not stop drives");
    irq_gate_a: assert property (!ctl[7] |-> !irq_out)
        else $error("irq without global enable");
endmodule // fault_prot_properties
bind converter_fault_protection fault_prot_properties fault_prot_properties_i (
    .clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in,
    .wb_ack_out, .wb_err_out, .out_below_in, .out_above_in, .overtemp_in,
    .pwm_high_in, .pwm_low_in, .high_side_gate_drive_out, .low_side_gate_drive_out,
    .irq_out);

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "fault_prot_regs.vh"
module tb_top;
    logic clk_in = 0, rst_n_in = 0, cyc = 0, stb = 0, wen = 0, ph = 0, pl = 0;
    logic [5:0] adr = 0;
    logic [31:0] dat = 0, rdat;
    logic [4:0] lv = 0, cmp;
    logic ack, hi, lo, irq;
    logic [31:0] q[$];
    int fail_count = 0, compares = 0, cycles = 0;
    fault_comparators fault_comparators_i (.level_in(lv), .comp_out(cmp));
    converter_fault_protection converter_fault_protection_i (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(wen),
        .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .wb_err_out(), .supply_below_in(cmp[0]),
        .switch_drop_over_in(cmp[1]), .out_below_in(cmp[2]), .out_above_in(cmp[3]),
        .overtemp_in(cmp[4]), .pwm_high_in(ph), .pwm_low_in(pl),
        .high_side_gate_drive_out(hi), .low_side_gate_drive_out(lo), .irq_out(irq));
    initial forever #20 clk_in = ~clk_in;
    task end_of_test;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // a bus cycle never waits more than 20 edges for its ack
    task wb(input logic we, input [3:0] idx, input [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        {cyc, stb, wen, adr, dat} <= {2'b11, we, idx, 2'b00, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            end_of_test;
        end
        {cyc, stb} <= 2'b00;
    endtask
    task rd(input [3:0] idx, input [31:0] e);
        q.push_back(e);
        wb(0, idx, dat);
    endtask
    task drv(input [1:0] e);
        check({hi, lo}, e, "gate drives");
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            end_of_test;
        end
        if (ack === 1'b1 && !wen && q.size() > 0) check(rdat, q.pop_front(), "read data");
    end
    // ----
    // scenarios
    // ----
    initial begin
        logic [31:0] v;
        v = $urandom(32'h783f);
        tick(6);
        rst_n_in <= 1;
        for (int i = 0; i < 6; i++) rd(i, 0);
        repeat (4) begin
            v = $urandom;
            wb(1, `ADDR_MASK, v);
            wb(1, 4'h9, v);
            rd(`ADDR_MASK, v & 32'h1f);
            rd(4'h9, 0);
        end
        wb(1, `ADDR_MASK, 0);
        $display("test registers done");
        // everything disabled: levels are visible but raise no flag
        repeat (6) begin
            lv <= $urandom;
            {ph, pl} <= $urandom;
            tick(4);
            drv({ph, pl});
            rd(`ADDR_FLAGS, {27'h0, lv});
            rd(`ADDR_STATUS, 0);
        end
        lv <= 0;
        $display("test disabled done");
        wb(1, `ADDR_CTRL, 1 << `CTRL_LOCKOUT_EN);
        lv <= 5'h01;
        {ph, pl} <= 2'b11;
        tick(5);
        rd(`ADDR_STATUS, 1);
        drv(3);
        wb(1, `ADDR_CTRL, 1 | (1 << `CTRL_DRV_DIS));
        tick(2);
        drv(0);
        lv <= 0;
        tick(5);
        rd(`ADDR_STATUS, 0);
        $display("test input low done");
        for (int k = 0; k < 2; k++) begin
            wb(1, `ADDR_CTRL, 32'h80 | (32'h14 << k));
            wb(1, `ADDR_MASK, 32'h4 << k);
            // long enough for the checker's five-cycle shutdown window to see it
            lv <= 5'h04 << k;
            tick(6);
            lv <= 0;
            tick(6);
            rd(`ADDR_STATUS, 32'h4 << k);
            drv(0);
            check(irq, 1, "irq level");
            wb(1, `ADDR_MASK, 0);
            check(irq, 0, "irq masked");
            wb(1, `ADDR_STATUS, 32'h4 << k);
            tick(2);
            rd(`ADDR_STATUS, 0);
            drv(3);
        end
        $display("test output faults done");
        wb(1, `ADDR_CTRL, 1 << `CTRL_OC_EN);
        {ph, pl} <= 2'b00;
        lv <= 5'h02;
        tick(4);
        rd(`ADDR_STATUS, 0);
        for (int c = 0; c < 4; c++) begin
            wb(1, `ADDR_BLANK, c);
            for (int s = 0; s < 2; s++) begin
                ph <= 1;
                tick(2 * c + 1 + 4 * s);
                ph <= 0;
                tick(3);
                rd(`ADDR_STATUS, s << 1);
                wb(1, `ADDR_STATUS, 2);
            end
        end
        lv <= 0;
        $display("test overcurrent done");
        wb(1, `ADDR_CTRL, 1 << `CTRL_OVERTEMP_EN);
        {ph, pl} <= 2'b11;
        lv <= 5'h10;
        tick(5);
        drv(0);
        lv <= 0;
        $display("test overtemp done");
        end_of_test;
    end
endmodule // tb_top
